/* File: hdl/dmr_pkg.sv */
// Package for the mode register configuration block: command pins, field positions, reset values.
// Assumes one system clock at 100 MHz; all pins arrive synchronous to it.
package dmr_pkg;
    // Bank select codes that pick the mode registers one, two and three.
    localparam logic [2:0] DMR_BANK_ONE = 3'h1;
    localparam logic [2:0] DMR_BANK_TWO = 3'h2;
    localparam logic [2:0] DMR_BANK_THREE = 3'h3;
    // Mode register one fields.
    localparam int DMR_M1_DLL_OFF = 0;
    localparam int DMR_M1_DRV_LO = 1;
    localparam int DMR_M1_RTT_A = 2;
    localparam int DMR_M1_ADD_LAT_LO = 3;
    localparam int DMR_M1_ADD_LAT_HI = 4;
    localparam int DMR_M1_DRV_HI = 5;
    localparam int DMR_M1_RTT_B = 6;
    localparam int DMR_M1_WLEVEL = 7;
    localparam int DMR_M1_RTT_C = 9;
    localparam int DMR_M1_TSTROBE = 11;
    localparam int DMR_M1_QOFF = 12;
    // Mode register two fields.
    localparam int DMR_M2_PART_ARRAY_LO = 0;
    localparam int DMR_M2_WR_COL_LAT_LO = 3;
    localparam int DMR_M2_AUTO_RATE = 6;
    localparam int DMR_M2_EXT_TEMP = 7;
    localparam int DMR_M2_RTTWR_LO = 9;
    // Mode register three fields.
    localparam int DMR_M3_LOC_LO = 0;
    localparam int DMR_M3_PAT_EN = 2;
    // Write column latency code zero means five cycles.
    localparam logic [3:0] DMR_WR_COL_LAT_BASE = 4'h5;
    // Reset values of the three registers.
    localparam logic [13:0] DMR_M1_RESET = 14'h0000;
    localparam logic [13:0] DMR_M2_RESET = 14'h0000;
    localparam logic [13:0] DMR_M3_RESET = 14'h0000;
    // Command pins as sampled on one clock edge.
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] bank;
        logic [13:0] addr;
    } dmr_cmd_s;
    // Decoded termination and pin configuration.
    typedef struct packed {
        logic [2:0] rtt_nom;
        logic [1:0] rtt_wr;
        logic [1:0] drive_sel;
        logic out_off;
        logic mask_en;
        logic tstrobe_en;
        logic tstrobe_n_en;
    } dmr_pin_s;
    // Every piece of state of the block.
    typedef struct packed {
        logic [13:0] mode_reg_one;
        logic [13:0] mode_reg_two;
        logic [13:0] mode_reg_three;
        logic dll_run;
        logic [4:0] read_lat;
        logic [4:0] write_lat;
    } dmr_state_s;
endpackage : dmr_pkg

/* File: hdl/dmr_config.sv */
// Mode register one to three configuration block of a synchronous DRAM.
// Assumes command pins are sampled on clk_sys_in; base register latency arrives on read_column_latency_in.
// Operation
// RQ1 - DLL follows self refresh when enabled
// RQ2 - Controller waits lock time before reads
// RQ3 - Controller keeps clock enable high meanwhile
// RQ4 - Writes need DLL only with write termination
// RQ5 - Controller disables termination in DLL-off
// RQ6 - Controller clears write termination in DLL-off
// RQ7 - Driver impedance from bits one and five
// RQ8 - Write termination applies without nominal
// RQ9 - Latency adds additive part to column
// RQ10 - Additive code: zero, minus one, two
// RQ11 - Output disable bit floats all outputs
// RQ12 - Bit eleven picks mask or termination
// RQ13 - Termination strobe terminates, never drives
// RQ14 - Register two load on bank two
// RQ15 - Controller zeroes reserved register two bits
// RQ16 - No write termination during write leveling
// RQ17 - Partial array range reported for refresh
// RQ18 - Write latency is additive plus column
// RQ19 - Auto rate uses sensor, else bit seven
// RQ20 - Register three load on bank three
// RQ21 - Controller zeroes reserved register three bits
// RQ22 - Pattern location ignored when pattern off
// RQ23 - Register one load on bank one
`timescale 1ns/1ps
module dmr_config
    import dmr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire dmr_cmd_s cmd_in,
    input wire logic [3:0] read_column_latency_in,
    input wire logic self_refresh_in,
    input wire logic write_active_in,
    input wire logic sensor_hot_in,
    output logic [13:0] mode_reg_one_out,
    output logic [13:0] mode_reg_two_out,
    output logic [13:0] mode_reg_three_out,
    output logic dll_run_out,
    output logic dll_needed_out,
    output logic [4:0] read_latency_out,
    output logic [4:0] write_latency_out,
    output logic [1:0] additive_latency_code_out,
    output dmr_pin_s pin_cfg_out,
    output logic [2:0] active_termination_out,
    output logic [2:0] partial_array_refresh_out,
    output logic fast_refresh_rate_out,
    output logic predefined_pattern_reg_out,
    output logic [1:0] pattern_location_out
);

    // Registered state and its next value.
    dmr_state_s state_q;
    dmr_state_s state_d;
    // True when the pins show a mode register write command.
    logic mode_reg_write_cmd;
    // Additive latency in cycles, derived from register one.
    logic [4:0] additive_latency;

    // Turns a two bit additive code into cycles; reserved code gives zero.
    function automatic logic [4:0] dmr_additive(input logic [1:0] code, input logic [3:0] col);
        logic [4:0] res;
        res = 5'h00;
        case (code)
            2'h1:
            begin
                res = {1'b0, col} - 5'h01; // RQ10
            end
            2'h2:
            begin
                res = {1'b0, col} - 5'h02; // RQ10
            end
            default:
            begin
                res = 5'h00; // RQ10
            end
        endcase
        return res;
    endfunction : dmr_additive

    // Next state computation for the three registers and the derived timing.
    always_comb
    begin
        state_d = state_q;
        // All four strobes low is the mode register write command.
        mode_reg_write_cmd = !cmd_in.cs_n && !cmd_in.ras_n && !cmd_in.cas_n && !cmd_in.we_n;
        if (mode_reg_write_cmd)
        begin
            // Reserved address bits are stored as given; the controller keeps those of registers two and three zero.
            case (cmd_in.bank)
                DMR_BANK_ONE:
                begin
                    state_d.mode_reg_one = cmd_in.addr; // RQ23
                end
                DMR_BANK_TWO:
                begin
                    state_d.mode_reg_two = cmd_in.addr; // RQ14
                end
                DMR_BANK_THREE:
                begin
                    state_d.mode_reg_three = cmd_in.addr; // RQ20
                end
                default:
                begin
                    // Base register and unused banks are handled elsewhere.
                    state_d.mode_reg_one = state_q.mode_reg_one;
                end
            endcase
        end
        // The DLL runs when enabled and drops out during self refresh, back on exit.
        state_d.dll_run = !state_d.mode_reg_one[DMR_M1_DLL_OFF] && !self_refresh_in; // RQ1
        additive_latency = dmr_additive(state_d.mode_reg_one[DMR_M1_ADD_LAT_HI:DMR_M1_ADD_LAT_LO],
            read_column_latency_in);
        // Read latency is the sum of additive and column latency.
        state_d.read_lat = additive_latency + {1'b0, read_column_latency_in}; // RQ9
        // Write latency is additive plus the decoded write column latency.
        state_d.write_lat = additive_latency + {2'b00, state_d.mode_reg_two[DMR_M2_WR_COL_LAT_LO +: 3]}
            + {1'b0, DMR_WR_COL_LAT_BASE}; // RQ18
    end

    // Single register stage for all state, synchronous reset.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_q.mode_reg_one <= DMR_M1_RESET;
            state_q.mode_reg_two <= DMR_M2_RESET;
            state_q.mode_reg_three <= DMR_M3_RESET;
            state_q.dll_run <= 1'b0;
            state_q.read_lat <= 5'h00;
            state_q.write_lat <= 5'h00;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Register contents for the rest of the device.
    assign mode_reg_one_out = state_q.mode_reg_one;
    assign mode_reg_two_out = state_q.mode_reg_two;
    assign mode_reg_three_out = state_q.mode_reg_three;
    assign dll_run_out = state_q.dll_run;
    assign read_latency_out = state_q.read_lat;
    assign write_latency_out = state_q.write_lat;
    assign additive_latency_code_out = state_q.mode_reg_one[DMR_M1_ADD_LAT_HI:DMR_M1_ADD_LAT_LO];

    // Writes only need the DLL when write termination is programmed.
    assign dll_needed_out = (write_active_in && (state_q.mode_reg_two[DMR_M2_RTTWR_LO +: 2] != 2'h0))
        || (!write_active_in); // RQ4

    // Pin function decode from registers one and two.
    always_comb
    begin
        pin_cfg_out.rtt_nom = {state_q.mode_reg_one[DMR_M1_RTT_C], state_q.mode_reg_one[DMR_M1_RTT_B],
            state_q.mode_reg_one[DMR_M1_RTT_A]};
        pin_cfg_out.rtt_wr = state_q.mode_reg_two[DMR_M2_RTTWR_LO +: 2];
        // Impedance select comes from bits five and one.
        pin_cfg_out.drive_sel = {state_q.mode_reg_one[DMR_M1_DRV_HI], state_q.mode_reg_one[DMR_M1_DRV_LO]}; // RQ7
        // Output disable floats data and strobes.
        pin_cfg_out.out_off = state_q.mode_reg_one[DMR_M1_QOFF]; // RQ11
        // Shared pin is mask when termination strobe is off, complement pin then floats.
        pin_cfg_out.mask_en = !state_q.mode_reg_one[DMR_M1_TSTROBE]; // RQ12
        // Termination strobe pins only terminate; they never drive a strobe.
        pin_cfg_out.tstrobe_en = state_q.mode_reg_one[DMR_M1_TSTROBE]; // RQ13
        pin_cfg_out.tstrobe_n_en = state_q.mode_reg_one[DMR_M1_TSTROBE]; // RQ12
    end

    // Termination value in force: write value during writes, never in write leveling.
    always_comb
    begin
        active_termination_out = pin_cfg_out.rtt_nom;
        if (write_active_in && !state_q.mode_reg_one[DMR_M1_WLEVEL]
            && (pin_cfg_out.rtt_wr != 2'h0)) // RQ16
        begin
            // Write value applies even with nominal termination off.
            active_termination_out = {1'b1, pin_cfg_out.rtt_wr}; // RQ8
        end
    end

    // Self refresh array range and rate selection.
    assign partial_array_refresh_out = state_q.mode_reg_two[DMR_M2_PART_ARRAY_LO +: 3]; // RQ17
    assign fast_refresh_rate_out = state_q.mode_reg_two[DMR_M2_AUTO_RATE] ? sensor_hot_in
        : state_q.mode_reg_two[DMR_M2_EXT_TEMP]; // RQ19

    // Pattern location only means something with the pattern register on.
    assign predefined_pattern_reg_out = state_q.mode_reg_three[DMR_M3_PAT_EN];
    assign pattern_location_out = state_q.mode_reg_three[DMR_M3_PAT_EN]
        ? state_q.mode_reg_three[DMR_M3_LOC_LO +: 2] : 2'h0; // RQ22

endmodule : dmr_config

/* File: testbench/dmr_ctrl_model.sv */
// Controller model: issues mode register writes on the command pins.
// Assumes the bench calls send() one command at a time from its main sequence.
`timescale 1ns/1ps
module dmr_ctrl_model
    import dmr_pkg::*;
(
    input wire logic clk_sys_in,
    output dmr_cmd_s cmd_out
);
    logic dll_off = 1'b0; // Mirror of the DLL-off bit last written.
    initial cmd_out = '1;
    // The model issues no read, no termination command and no clock-enable change, so lock wait is kept.
    localparam bit NO_READS_DURING_LOCK = 1'b1;
    // One command for one edge, then deselect with the lines inverted so stale values never look valid.
    task automatic send(input logic [2:0] bank, input logic [13:0] addr);
        logic [13:0] a;
        a = addr;
        if (bank == 3'h1 && (dll_off || addr[0])) a = a & 14'h3DBB;
        if (bank == 3'h2) a = a & (dll_off ? 14'h00FF : 14'h06FF);
        if (bank == 3'h3) a = a & 14'h0007;
        if (bank == 3'h1) dll_off = addr[0];
        @(posedge clk_sys_in);
        cmd_out <= {4'h0, bank, a};
        @(posedge clk_sys_in);
        cmd_out <= {4'hF, ~bank, ~a};
    endtask : send
endmodule : dmr_ctrl_model

/* File: testbench/dmr_config_properties.sv */
// Checker for the mode register block; it sees only the block's ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module dmr_config_properties
    import dmr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire dmr_cmd_s cmd_in,
    input wire logic [3:0] read_column_latency_in,
    input wire logic self_refresh_in,
    input wire logic write_active_in,
    input wire logic [13:0] mode_reg_one_out,
    input wire logic [13:0] mode_reg_two_out,
    input wire logic [13:0] mode_reg_three_out,
    input wire logic dll_run_out,
    input wire logic dll_needed_out,
    input wire logic [4:0] read_latency_out,
    input wire logic [4:0] write_latency_out,
    input wire dmr_pin_s pin_cfg_out,
    input wire logic [2:0] active_termination_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    wire [13:0] m1 = mode_reg_one_out; // Short aliases keep the properties readable.
    wire [1:0] rw = mode_reg_two_out[10:9];
    wire mode_wr = !(cmd_in.cs_n | cmd_in.ras_n | cmd_in.cas_n | cmd_in.we_n); // All four strobes low.
    wire [4:0] col_lat = 5'(read_column_latency_in);
    // The reserved additive code counts as zero.
    wire [4:0] add_lat = (m1[4:3] == 2'h1) ? col_lat - 5'h1 : (m1[4:3] == 2'h2) ? col_lat - 5'h2 : 5'h0;
    wire [2:0] tx = (write_active_in && rw != 2'h0 && !m1[7]) ? {1'b1, rw} : {m1[9], m1[6], m1[2]};
    a_reg_one_load: assert property (mode_wr && cmd_in.bank == 3'h1 |=> m1 == $past(cmd_in.addr))
        else $error("register one not loaded");
    a_reg_two_load: assert property (mode_wr && cmd_in.bank == 3'h2 |=> mode_reg_two_out == $past(cmd_in.addr))
        else $error("register two not loaded");
    a_reg_three_load: assert property (mode_wr && cmd_in.bank == 3'h3 |=> mode_reg_three_out == $past(cmd_in.addr))
        else $error("register three not loaded");
    a_dll_follows_refresh: assert property ((!m1[0] && $stable(self_refresh_in))[*3] |-> dll_run_out == !self_refresh_in)
        else $error("dll does not follow self refresh");
    a_write_dll_need: assert property (dll_needed_out == !(write_active_in && rw == 2'h0))
        else $error("dll need wrong");
    a_read_latency_sum: assert property (($stable(m1) && $stable(col_lat))[*3] |-> read_latency_out == col_lat + add_lat)
        else $error("read latency wrong");
    a_write_latency_sum: assert property (
        ($stable(m1) && $stable(mode_reg_two_out) && $stable(col_lat))[*3]
        |-> write_latency_out == add_lat + 5'(mode_reg_two_out[5:3]) + 5'(DMR_WR_COL_LAT_BASE))
        else $error("write latency wrong");
    a_pin_config_map: assert property (pin_cfg_out[5:0] == {m1[5], m1[1], m1[12], !m1[11], m1[11], m1[11]})
        else $error("pin configuration wrong");
    a_write_term_pick: assert property (active_termination_out == tx)
        else $error("active termination wrong");
endmodule : dmr_config_properties
bind dmr_config dmr_config_properties u_dmr_config_properties (.*);

/* File: testbench/tb_top.sv */
// Top bench: issues register writes and side inputs, compares outputs with decoded expectations.
// Assumes the controller model and the checker are compiled before it.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module tb_top
    import dmr_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] col_lat = 4'h6; // Column latency held at six throughout.
    logic sr = 1'b0, wa = 1'b0, hot = 1'b0;
    int n_fail = 0;
    int total_checks = 0;
    wire dmr_cmd_s cmd;
    wire dmr_pin_s pin;
    wire [13:0] r1, r2, r3;
    wire run, need, fast, pat;
    wire [4:0] rd_lat, wr_lat;
    wire [1:0] alc, loc;
    wire [2:0] term, partial_array_refresh;
    always #5 clk_sys_in = ~clk_sys_in;
    dmr_ctrl_model u_dmr_ctrl_model (.clk_sys_in, .cmd_out(cmd));
    dmr_config u_dmr_config (.clk_sys_in, .rst_in, .cmd_in(cmd), .read_column_latency_in(col_lat), .self_refresh_in(sr),
        .write_active_in(wa), .sensor_hot_in(hot), .mode_reg_one_out(r1), .mode_reg_two_out(r2),
        .mode_reg_three_out(r3), .dll_run_out(run), .dll_needed_out(need), .read_latency_out(rd_lat),
        .write_latency_out(wr_lat), .additive_latency_code_out(alc), .pin_cfg_out(pin), .active_termination_out(term),
        .partial_array_refresh_out(partial_array_refresh), .fast_refresh_rate_out(fast), .predefined_pattern_reg_out(pat),
        .pattern_location_out(loc));
    // Write one register and let the registered latencies settle.
    task automatic wr(input logic [2:0] b, input logic [13:0] a);
        u_dmr_ctrl_model.send(b, a);
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask : wr
    // Change the level inputs on an edge, then let them settle.
    task automatic side(input logic s, input logic w, input logic h);
        @(posedge clk_sys_in);
        sr <= s;
        wa <= w;
        hot <= h;
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask : side
    // Print the counts and the verdict, then stop.
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    // A hang is cut short here and counted.
    initial
    begin
        repeat (5000) @(posedge clk_sys_in);
        n_fail++;
        results();
    end
    initial
    begin
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        `CHK({r1, r2, r3, run}, {DMR_M1_RESET, DMR_M2_RESET, DMR_M3_RESET, 1'b1})
        for (int c = 0; c < 4; c++)
        begin
            wr(3'h1, 14'(c << 3));
            `CHK({alc, rd_lat}, {2'(c), 5'h6 + ((c == 1) ? 5'h5 : (c == 2) ? 5'h4 : 5'h0)})
        end
        wr(3'h2, 14'h0018);
        `CHK(wr_lat, 5'h08)
        wr(3'h1, 14'h0008);
        `CHK(wr_lat, 5'h0D)
        wr(3'h0, 14'h3FFF);
        wr(3'h4, 14'h3FFF);
        `CHK({r1, r2, r3}, {14'h0008, 14'h0018, 14'h0000})
        wr(3'h1, 14'h1820);
        `CHK(pin, {3'h0, 2'h0, 2'h2, 4'hB})
        wr(3'h1, 14'h0002);
        `CHK(pin, {3'h0, 2'h0, 2'h1, 4'h4})
        wr(3'h1, 14'h0004);
        wr(3'h2, 14'h0400);
        `CHK(term, 3'h1)
        side(1'b0, 1'b1, 1'b0);
        `CHK({term, need}, {3'h6, 1'b1})
        wr(3'h1, 14'h0084);
        `CHK(term, 3'h1)
        wr(3'h1, 14'h0000);
        `CHK(term, 3'h6)
        wr(3'h2, 14'h0000);
        `CHK({term, need}, {3'h0, 1'b0})
        wr(3'h2, 14'h0045);
        side(1'b0, 1'b0, 1'b1);
        `CHK({partial_array_refresh, fast}, {3'h5, 1'b1})
        wr(3'h2, 14'h00C0);
        side(1'b0, 1'b0, 1'b0);
        `CHK(fast, 1'b0)
        wr(3'h2, 14'h0080);
        `CHK(fast, 1'b1)
        wr(3'h3, 14'h0003);
        `CHK({pat, loc}, 3'h0)
        wr(3'h3, 14'h0007);
        `CHK({pat, loc}, 3'h7)
        side(1'b1, 1'b0, 1'b0);
        `CHK(run, 1'b0)
        side(1'b0, 1'b0, 1'b0);
        `CHK(run, 1'b1)
        wr(3'h1, 14'h0001);
        `CHK(run, 1'b0)
        results();
    end
endmodule : tb_top
